// >>> tsa_map.svh
// constants for the temperature sensor access and timeout block
`ifndef TSA_MAP_SVH
`define TSA_MAP_SVH

// ============================================================
// clock and timing
`define TSA_CLK_HZ        40000000
`define TSA_TIMEOUT_MS    100
`define TSA_TIMEOUT_CYC   ((`TSA_TIMEOUT_MS) * (`TSA_CLK_HZ / 1000))
`define TSA_CONV_MS       100
`define TSA_CONV_CYC      ((`TSA_CONV_MS) * (`TSA_CLK_HZ / 1000))
`define TSA_CNT_W         23

// ============================================================
// fault queue and reset values
`define TSA_FAULT_MAX     3'h6
`define TSA_FAULT_MIN     3'h1
`define TSA_TEMP_RST      9'h000
`define TSA_PIN_IDLE      1'h1

`endif

// >>> tsa_pkg.sv
// types for the temperature sensor access and timeout block
`default_nettype none

package tsa_pkg;

  typedef logic signed [8:0] tsa_temp_t;

  // conversion sequencer, gray coded except the HOLD to OFF step on shutdown
  typedef enum logic [1:0] {
    TSA_CV_OFF  = 2'h0,
    TSA_CV_RUN  = 2'h1,
    TSA_CV_HOLD = 2'h3
  } tsa_conv_e;

  // thresholds and fault queue depth
  typedef struct packed {
    tsa_temp_t   over_temp_limit;
    tsa_temp_t   hysteresis_limit;
    logic [2:0]  fault_sel;
  } tsa_limits_s;

  // whole block state
  typedef struct packed {
    logic        scl_d;
    logic        sda_d;
    logic        bus_active;
    logic        timed_out;
    logic [22:0] to_cnt;
    tsa_conv_e   conv_st;
    logic [22:0] conv_cnt;
    tsa_temp_t   temp_result;
    logic [2:0]  fault_cnt;
    logic        alarm;
    logic        sda_oe;
    logic        sda_out;
    logic        conv_run;
  } tsa_state_s;

endpackage
`default_nettype wire

// >>> tsa_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
`include "tsa_map.svh"

module tsa_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);

  logic [W-1:0] meta;

  // ============================================================
  // synchroniser chain; meta feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta <= {W{`TSA_PIN_IDLE}};
      dout <= {W{`TSA_PIN_IDLE}};
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule
`default_nettype wire

// >>> tsa_top.sv
// temperature sensor bus access, conversion scheduling and bus-stuck timeout
// Behaviour
// R1: if the data line stays low past the bus-stuck timeout (75 to 325 ms) the serial interface goes idle and releases data.
// R2: a bus access aborts any running conversion, and a fresh one starts once the access ends.
// R3: the result always shows the last completed conversion, even while a new one runs.
// R4: the result changes only when a conversion completes, so tightly spaced accesses leave it unchanged.
// R5: the controller should leave at least 300 ms idle between accesses so a conversion can finish.
// R6: the alarm asserts only after a selectable number of over-limit conversions, at most 6.
// R7: over-limit conversions must be consecutive; any other conversion restarts the count.
// R8: after a timeout the interface stays idle with data released and ignores traffic until a new start.
// R9: the timeout watchdog is disabled in shutdown.
// R10: the timeout counter counts while data is sampled low and clears when it is sampled high.
`timescale 1ns/1ps
`default_nettype none
`include "tsa_map.svh"

module tsa_top #(
  parameter int unsigned TO_CYCLES   = `TSA_TIMEOUT_CYC,
  parameter int unsigned CONV_CYCLES = `TSA_CONV_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic                 scl_in,
  input  wire logic                 sda_in,
  input  wire logic                 sda_drive_low,
  input  wire logic                 shutdown,
  input  wire tsa_pkg::tsa_temp_t   adc_value,
  input  wire tsa_pkg::tsa_limits_s limits,
  output var  tsa_pkg::tsa_temp_t   temp_result,
  output var  logic                 alarm,
  output var  logic                 sda_out,
  output var  logic                 sda_oe,
  output var  logic                 bus_busy,
  output var  logic                 conv_busy
);
  import tsa_pkg::*;

  localparam logic [22:0] TO_LAST   = 23'(TO_CYCLES - 1);
  localparam logic [22:0] CONV_LAST = 23'(CONV_CYCLES - 1);

  tsa_state_s st;
  tsa_state_s next_st;
  logic [1:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       start_det;
  logic       stop_det;
  logic       to_fire;
  logic       conv_done;
  logic       over;
  logic       under;
  logic [2:0] need;

  // clamp queue depth to 1..6; zero would otherwise trip on nothing
  function automatic logic [2:0] tsa_depth(input logic [2:0] sel);
    if (sel == 3'h0) begin
      return `TSA_FAULT_MIN;
    end else if (sel > `TSA_FAULT_MAX) begin
      return `TSA_FAULT_MAX;
    end else begin
      return sel;
    end
  endfunction

  // signed greater-than, used for both thresholds
  function automatic logic tsa_gt(input tsa_temp_t a, input tsa_temp_t b);
    return a > b;
  endfunction

  // ============================================================
  // pin synchronisation
  tsa_sync #(
    .W (2)
  ) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .din   ({scl_in, sda_in}),
    .dout  (pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // ============================================================
  // event decode
  assign start_det = scl_s && st.scl_d && st.sda_d && !sda_s;
  assign stop_det  = scl_s && st.scl_d && !st.sda_d && sda_s;
  assign to_fire   = !shutdown && !sda_s && (st.to_cnt == TO_LAST);
  assign conv_done = (st.conv_st == TSA_CV_RUN) && (st.conv_cnt == CONV_LAST)
                     && !st.bus_active && !shutdown;
  assign over      = tsa_gt(adc_value, limits.over_temp_limit);
  assign under     = tsa_gt(limits.hysteresis_limit, adc_value);
  assign need      = tsa_depth(limits.fault_sel);

  // ============================================================
  // next-state logic
  always_comb begin
    next_st       = st;
    next_st.scl_d = scl_s;
    next_st.sda_d = sda_s;

    // watchdog: counts low data cycles, off in shutdown
    if (shutdown || sda_s) begin // R9
      next_st.to_cnt = 23'h0; // R10
    end else if (to_fire) begin
      next_st.to_cnt = 23'h0;
    end else begin
      next_st.to_cnt = st.to_cnt + 23'h1; // R10
    end

    // bus framing; a timeout drops the frame until a fresh start
    if (to_fire) begin
      next_st.bus_active = 1'b0; // R1
      next_st.timed_out  = 1'b1; // R8
    end else if (start_det) begin
      next_st.bus_active = 1'b1;
      next_st.timed_out  = 1'b0; // R8
    end else if (stop_det) begin
      next_st.bus_active = 1'b0;
    end

    // data released whenever idle or timed out
    next_st.sda_oe = next_st.bus_active && !next_st.timed_out && sda_drive_low; // R1 R8
    next_st.sda_out = 1'b0; // open drain only ever pulls low

    // conversion sequencer
    case (st.conv_st)
      TSA_CV_OFF: begin
        if (!shutdown) begin
          next_st.conv_st  = TSA_CV_RUN;
          next_st.conv_cnt = 23'h0;
        end
      end
      TSA_CV_RUN: begin
        if (shutdown) begin
          next_st.conv_st = TSA_CV_OFF;
        end else if (st.bus_active) begin
          next_st.conv_st = TSA_CV_HOLD; // R2
        end else if (conv_done) begin
          next_st.conv_cnt = 23'h0;
        end else begin
          next_st.conv_cnt = st.conv_cnt + 23'h1;
        end
      end
      TSA_CV_HOLD: begin
        if (shutdown) begin
          next_st.conv_st = TSA_CV_OFF;
        end else if (!st.bus_active) begin
          // controller is expected to stay away long enough to finish
          next_st.conv_st  = TSA_CV_RUN; // R2 R5
          next_st.conv_cnt = 23'h0;
        end
      end
      default: begin
        next_st.conv_st  = TSA_CV_OFF;
        next_st.conv_cnt = 23'h0;
      end
    endcase
    // busy flag kept in a flop so the output carries no decode glitch
    next_st.conv_run = (next_st.conv_st == TSA_CV_RUN);

    // result and fault queue, only on a completed conversion
    if (conv_done) begin
      next_st.temp_result = adc_value; // R3 R4
      if (over) begin
        if (st.fault_cnt < `TSA_FAULT_MAX) begin
          next_st.fault_cnt = st.fault_cnt + 3'h1;
        end
        if ((st.fault_cnt + 3'h1) >= need) begin
          next_st.alarm = 1'b1; // R6
        end
      end else begin
        next_st.fault_cnt = 3'h0; // R7
        if (under) begin
          next_st.alarm = 1'b0;
        end
      end
    end
  end

  // ============================================================
  // state register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st             <= '0;
      st.scl_d       <= `TSA_PIN_IDLE;
      st.sda_d       <= `TSA_PIN_IDLE;
      st.conv_st     <= TSA_CV_OFF;
      st.temp_result <= `TSA_TEMP_RST;
    end else begin
      st <= next_st;
    end
  end

  assign temp_result = st.temp_result;
  assign alarm       = st.alarm;
  assign sda_oe      = st.sda_oe;
  assign bus_busy    = st.bus_active;
  assign conv_busy   = st.conv_run;
  assign sda_out     = st.sda_out;

  // ============================================================
  // checks
  property p_timeout_idle;
    @(posedge clk) disable iff (!rst_b)
    to_fire |=> (!st.bus_active && !sda_oe && st.timed_out);
  endproperty
  a_timeout_idle: assert property (p_timeout_idle) else $error("timeout did not idle the interface"); // R1

  property p_abort;
    @(posedge clk) disable iff (!rst_b)
    (st.bus_active && st.conv_st == TSA_CV_RUN && !shutdown) |=> (st.conv_st == TSA_CV_HOLD);
  endproperty
  a_abort: assert property (p_abort) else $error("access did not abort conversion"); // R2

  property p_restart;
    @(posedge clk) disable iff (!rst_b)
    (st.conv_st == TSA_CV_HOLD && !st.bus_active && !shutdown) |=> (conv_busy && st.conv_cnt == 23'h0);
  endproperty
  a_restart: assert property (p_restart) else $error("conversion not restarted after access"); // R2

  property p_result_load;
    @(posedge clk) disable iff (!rst_b)
    conv_done |=> (temp_result == $past(adc_value));
  endproperty
  a_result_load: assert property (p_result_load) else $error("result not loaded on completion"); // R3

  property p_result_hold;
    @(posedge clk) disable iff (!rst_b)
    (st.bus_active && !conv_done) |=> $stable(temp_result) ##1 $stable(temp_result);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result changed without completion"); // R4

  property p_alarm_cause;
    @(posedge clk) disable iff (!rst_b)
    $rose(alarm) |-> ($past(conv_done) && $past(over) && ($past(st.fault_cnt) + 3'h1 >= $past(need)));
  endproperty
  a_alarm_cause: assert property (p_alarm_cause) else $error("alarm rose without enough faults"); // R6

  property p_fault_clear;
    @(posedge clk) disable iff (!rst_b)
    (conv_done && !over) |=> (st.fault_cnt == 3'h0);
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("fault count not restarted"); // R7

  property p_quiet;
    @(posedge clk) disable iff (!rst_b)
    (st.timed_out && !start_det) |=> (!st.bus_active && !sda_oe);
  endproperty
  a_quiet: assert property (p_quiet) else $error("interface active after timeout"); // R8

  property p_wd_off;
    @(posedge clk) disable iff (!rst_b)
    shutdown |=> (st.to_cnt == 23'h0 && !$past(to_fire));
  endproperty
  a_wd_off: assert property (p_wd_off) else $error("watchdog ran in shutdown"); // R9

  property p_wd_count;
    @(posedge clk) disable iff (!rst_b)
    (!shutdown && !sda_s && !to_fire) |=> (st.to_cnt == $past(st.to_cnt) + 23'h1);
  endproperty
  a_wd_count: assert property (p_wd_count) else $error("watchdog did not count"); // R10

endmodule
`default_nettype wire

// >>> tsa_bus_model.sv
// bus controller model driving the two-wire clock and data lines
`timescale 1ns/1ps
`default_nettype none

module tsa_bus_model (
  input  wire logic clk,
  output var  logic scl,
  output var  logic sda
);
  // ============================================================
  // released lines sit high, as the pull-ups would leave them
  initial begin
    scl = 1'h1;
    sda = 1'h1;
  end

  // one line change per edge, with the bench's small skew
  task automatic step(input logic c, input logic d);
    @(posedge clk);
    #2;
    scl = c;
    sda = d;
  endtask

  // data falls with clock high; data released once clock is low
  task automatic start();
    step(1'h1, 1'h1);
    step(1'h1, 1'h0);
    step(1'h0, 1'h0);
    step(1'h0, 1'h1);
  endtask

  // data rises with clock high to close the frame
  task automatic stop();
    step(1'h0, 1'h0);
    step(1'h1, 1'h0);
    step(1'h1, 1'h1);
  endtask

  // quiet gap between accesses so a conversion can finish
  task automatic idle(input int n);
    repeat (n) step(1'h1, 1'h1);
  endtask
endmodule

`default_nettype wire

// >>> tb.sv
// self-checking bench for the sensor access and timeout block
`timescale 1ns/1ps
`default_nettype none

module tb;
  import tsa_pkg::*;

  // ============================================================
  // stimulus and wiring
  logic        clk = 1'h0;
  logic        rst_b = 1'h0;
  logic        drv_low;
  logic        shutdown;
  tsa_temp_t   adc_value;
  tsa_limits_s limits;
  tsa_temp_t   temp_result;
  logic        alarm, sda_out, sda_oe, bus_busy, conv_busy;
  wire  logic  scl_w, m_sda, sda_w;
  int          errors = 0;
  int          n_tests = 0;
  int          cycles = 0;

  // device pulls low only when enabled; pull-up otherwise
  assign sda_w = m_sda & (sda_oe ? sda_out : 1'h1);

  always #12.5 clk = ~clk;

  tsa_bus_model m (.clk(clk), .scl(scl_w), .sda(m_sda));

  // short counts keep the run brief
  tsa_top #(.TO_CYCLES(50), .CONV_CYCLES(40)) uut (
    .clk(clk), .rst_b(rst_b), .scl_in(scl_w), .sda_in(sda_w),
    .sda_drive_low(drv_low), .shutdown(shutdown), .adc_value(adc_value),
    .limits(limits), .temp_result(temp_result), .alarm(alarm),
    .sda_out(sda_out), .sda_oe(sda_oe), .bus_busy(bus_busy),
    .conv_busy(conv_busy));

  // ============================================================
  // shared helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // bounded wait for a completion carrying v
  task automatic conv(input logic [8:0] v, input logic a);
    int k;
    adc_value = v;
    k = 0;
    while (temp_result !== v && k < 60) begin
      cyc(1);
      k++;
    end
    cyc(1);
    chk("temp_result", temp_result, v);
    chk("alarm", alarm, {8'h00, a});
  endtask

  // ============================================================
  // scenarios
  task automatic t_alarm();
    conv(9'h065, 1'h0);
    conv(9'h066, 1'h0);
    conv(9'h032, 1'h0);
    conv(9'h067, 1'h0);
    conv(9'h068, 1'h0);
    conv(9'h069, 1'h1);
    conv(9'h050, 1'h0);
  endtask

  // fault depth clamped at both ends, and limits compared as signed
  task automatic t_limits();
    limits = '{9'h1ec, 9'h1e2, 3'h0};
    conv(9'h005, 1'h1);
    conv(9'h1d8, 1'h0);
    limits = '{9'h064, 9'h05a, 3'h7};
    conv(9'h06b, 1'h0);
    conv(9'h06c, 1'h0);
    conv(9'h06d, 1'h0);
    conv(9'h06e, 1'h0);
    conv(9'h06f, 1'h0);
    conv(9'h070, 1'h1);
    conv(9'h05f, 1'h1);
    conv(9'h050, 1'h0);
    limits.fault_sel = 3'h3;
  endtask

  task automatic t_abort();
    conv(9'h014, 1'h0);
    adc_value = 9'h01e;
    m.start();
    cyc(6);
    chk("bus_busy", bus_busy, 9'h001);
    chk("conv_busy", conv_busy, 9'h000);
    cyc(60);
    chk("held result", temp_result, 9'h014);
    m.stop();
    cyc(6);
    chk("restart", conv_busy, 9'h001);
    cyc(25);
    chk("no early load", temp_result, 9'h014);
    conv(9'h01e, 1'h0);
    m.idle(10);
  endtask

  task automatic t_timeout();
    m.start();
    drv_low = 1'h1;
    cyc(5);
    chk("sda_oe", sda_oe, 9'h001);
    chk("sda_out", sda_out, 9'h000);
    cyc(35);
    drv_low = 1'h0;
    cyc(3);
    drv_low = 1'h1;
    cyc(40);
    chk("count cleared", bus_busy, 9'h001);
    cyc(20);
    chk("idle", bus_busy, 9'h000);
    chk("released", sda_oe, 9'h000);
    cyc(10);
    chk("ignored", sda_oe, 9'h000);
    drv_low = 1'h0;
    m.idle(5);
    m.start();
    cyc(6);
    chk("new start", bus_busy, 9'h001);
    m.stop();
    m.idle(5);
  endtask

  task automatic t_shutdown();
    shutdown = 1'h1;
    m.start();
    drv_low = 1'h1;
    cyc(80);
    chk("no timeout", bus_busy, 9'h001);
    chk("no conv", conv_busy, 9'h000);
    drv_low = 1'h0;
    m.stop();
    shutdown = 1'h0;
    m.idle(5);
  endtask

  // ============================================================
  // main sequence and hang guard
  initial begin
    drv_low   = 1'h0;
    shutdown  = 1'h0;
    adc_value = 9'h000;
    limits    = '{9'h064, 9'h05a, 3'h3};
    cyc(5);
    rst_b = 1'h1;
    cyc(1);
    chk("reset temp", temp_result, 9'h000);
    chk("reset alarm", alarm, 9'h000);
    chk("reset oe", sda_oe, 9'h000);
    chk("reset sda_out", sda_out, 9'h000);
    chk("reset bus", bus_busy, 9'h000);
    chk("conv start", conv_busy, 9'h001);
    t_alarm();
    t_limits();
    t_abort();
    t_timeout();
    t_shutdown();
    summarize();
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
  end
endmodule

`default_nettype wire
